// ==== vec_pkt_pkg.sv ====
// shared constants and types for the vector packet formatter
`default_nettype none
package vec_pkt_pkg;
    // vector type codes
    localparam logic [2:0] VT_SECURE = 3'h0;
    localparam logic [2:0] VT_SHORT_INSTR = 3'h1;
    localparam logic [2:0] VT_NUM_STD = 3'h3;
    localparam logic [2:0] VT_NUM_SPECIAL = 3'h4;
    localparam logic [2:0] VT_ALPHA = 3'h5;
    localparam logic [2:0] VT_HEX_BIN = 3'h6;
    localparam logic [2:0] VT_NUM_NUMBERED = 3'h7;
    // field ranges
    localparam logic [6:0] WORD_LOC_MIN = 7'h02;
    localparam logic [6:0] WORD_LOC_MAX = 7'h57;
    localparam logic [6:0] START_MIN = 7'h03;
    localparam logic [6:0] START_MAX = 7'h57;
    localparam logic [6:0] COUNT_MIN = 7'h01;
    localparam logic [6:0] COUNT_MAX = 7'h55;
    localparam logic [2:0] NUM_LEN_ONE = 3'h0;
    localparam logic [6:0] NUM_CNT_MAX = 7'h08;
    localparam logic [6:0] LONG_STEP = 7'h01;
    localparam logic [1:0] BIT_ERR_LIMIT = 2'h2;
    // register map
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CLEAR = 4'h1;
    localparam logic [3:0] ADDR_ENABLE = 4'h2;
    localparam logic [3:0] ADDR_LAST_PKT = 4'h3;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam int EV_W = 3;
    localparam int EV_SENT = 0;
    localparam int EV_ERR = 1;
    localparam int EV_MSG = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // decoded vector word from the frame processor
    typedef struct packed {
        logic [6:0] word_loc;
        logic [1:0] phase;
        logic [2:0] vtype;
        logic [1:0] bit_errs;  // saturating: 3 means more than two
        logic check_fail;
        logic invalid;
        logic long_addr;
        logic [3:0] check_bits;
        logic [6:0] word_count; // message words in frame
        logic [6:0] start_word;
        logic [10:0] instr_data;
        logic [2:0] instr_type;
    } vector_in_s;

    // packet toward the host, byte 3 first
    typedef struct packed {
        logic [31:0] bytes;
        logic err;
        logic has_msg;
        logic [6:0] first_msg_loc;
    } packet_out_s;
endpackage : vec_pkt_pkg
`default_nettype wire

// ==== vector_packet_formatter.sv ====
// formats decoded vector words into four-byte host packets
// Function
// [R1] byte 3: bit 7 zero, 7-bit vector word location 2..87
// [R2] error flag: over two bit errors, check fail, or invalid vector
// [R3] byte 2 bits 6:5 carry phase, 0 = a through 3 = d
// [R4] numeric packet carries beginning check bits in byte 1 bits 5:2
// [R5] numeric length is word count minus one, long address included
// [R6] numeric long address: first message word follows the vector
// [R7] numeric start field: word 3..87, second word on long address
// [R8] message layout: e, phase, unused, type; 7-bit count, 7-bit start
// [R9] message type codes: 000 secure, 101 alpha, 110 hex/binary
// [R10] message word count 1..85, includes word after long vector
// [R11] message start 3..87; on long address points at second word
// [R12] long address message vector: first message follows vector
// [R13] host ignores unused bits; their value is not guaranteed
// [R14] short instruction: 11 data bits then 3-bit instruction type
// [R15] type 001 marks a short instruction vector
// [R16] numeric type codes: 011 standard, 100 special, 111 numbered
// [R17] message packets only if error clear and message words exist
// [R18] four bytes per packet, byte 3 most significant
//
// Strobed register access and the address map are this design's own decisions.
`default_nettype none
module vector_packet_formatter
    import vec_pkt_pkg::*;
#(
    // width of the received-vector counter
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // decoded vector from frame logic
    input wire logic vec_valid_i,
    input wire vector_in_s vec_i,
    // packet toward serial link
    output logic pkt_valid_o,
    output packet_out_s pkt_o,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // interrupt
    output logic irq_o
);

    // the counter is read back through a 32-bit register window
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
        $error("vector counter width out of range");
    end

    // type classification
    wire logic type_std = vec_i.vtype == VT_NUM_STD; // R16
    wire logic type_special = vec_i.vtype == VT_NUM_SPECIAL; // R16
    wire logic type_numbered = vec_i.vtype == VT_NUM_NUMBERED; // R16
    wire logic type_secure = vec_i.vtype == VT_SECURE; // R9
    wire logic type_alpha = vec_i.vtype == VT_ALPHA; // R9
    wire logic type_hex = vec_i.vtype == VT_HEX_BIN; // R9
    wire logic is_numeric = type_std || type_special || type_numbered;
    wire logic is_message = type_secure || type_alpha || type_hex;
    wire logic is_short = vec_i.vtype == VT_SHORT_INSTR; // R15
    // codes outside the three layouts cannot be formatted
    wire logic type_bad = !(is_numeric || is_message || is_short);

    // word location range, every layout
    wire logic loc_low = vec_i.word_loc < WORD_LOC_MIN; // R1
    wire logic loc_high = vec_i.word_loc > WORD_LOC_MAX; // R1
    wire logic loc_bad = loc_low || loc_high;

    // message start range, numeric and message layouts
    wire logic start_low = vec_i.start_word < START_MIN; // R7 R11
    wire logic start_high = vec_i.start_word > START_MAX; // R7 R11
    wire logic start_bad = start_low || start_high;

    // word count range
    wire logic count_low = vec_i.word_count < COUNT_MIN; // R10
    wire logic count_high = vec_i.word_count > COUNT_MAX; // R10
    wire logic count_bad = count_low || count_high;

    // three length bits cannot say more than eight words
    wire logic num_cnt_bad = vec_i.word_count > NUM_CNT_MAX; // R5

    // range faults fold into the invalid judgement
    wire logic num_range_bad = is_numeric &&
        (start_bad || count_bad || num_cnt_bad);
    wire logic msg_range_bad = is_message &&
        (start_bad || count_bad);
    wire logic range_bad = loc_bad ||
        num_range_bad ||
        msg_range_bad;

    // error flag causes
    wire logic too_many_errs = vec_i.bit_errs > BIT_ERR_LIMIT; // R2
    wire logic check_failed = vec_i.check_fail; // R2
    wire logic judged_bad = vec_i.invalid ||
        range_bad ||
        type_bad; // R2
    wire logic err_flag = too_many_errs ||
        check_failed ||
        judged_bad; // R2

    // numeric length: count already holds the long address word
    wire logic [6:0] count_less_one =
        7'(vec_i.word_count - COUNT_MIN); // R5
    wire logic [2:0] num_len = count_less_one[2:0]; // R5

    // byte 3: zero flag bit over the vector word location
    wire logic [7:0] byte3 = {1'b0, vec_i.word_loc}; // R1

    // byte 2: error, phase, two unused bits, type code
    wire logic [1:0] unused_b2 = 2'b00; // R8
    wire logic [7:0] byte2 = {err_flag,
        vec_i.phase,
        unused_b2,
        vec_i.vtype}; // R3 R8

    // unused bits driven zero, host must still ignore them
    wire logic [1:0] unused_b1 = 2'b00;
    wire logic [15:0] low_num = {unused_b1,
        vec_i.check_bits,
        num_len,
        vec_i.start_word}; // R4 R5 R7
    wire logic [15:0] low_msg = {unused_b1,
        vec_i.word_count,
        vec_i.start_word}; // R8 R10 R11
    wire logic [15:0] low_short = {unused_b1,
        vec_i.instr_data,
        vec_i.instr_type}; // R14

    // layout selection for the low half
    wire logic [15:0] low_sel = is_numeric ? low_num :
        (is_short ? low_short : low_msg);
    wire logic [31:0] packet_word = {byte3, byte2, low_sel}; // R18

    // message words follow only for clean vectors with words
    wire logic words_follow = is_numeric ||
        is_message ||
        (is_short && vec_i.long_addr);
    wire logic has_msg = !err_flag && words_follow; // R17

    // long address: first message word sits right after the vector
    wire logic [6:0] after_vector =
        7'(vec_i.word_loc + LONG_STEP); // R6 R12
    wire logic [6:0] first_loc = vec_i.long_addr ?
        after_vector : vec_i.start_word; // R6 R12

    packet_out_s pkt_next;
    always_comb begin
        pkt_next.bytes = packet_word; // R18
        pkt_next.err = err_flag;
        pkt_next.has_msg = has_msg;
        pkt_next.first_msg_loc = first_loc;
    end

    // packet register: holds until the next vector
    logic pkt_valid_reg;
    packet_out_s pkt_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pkt_valid_reg <= 1'b0;
            pkt_reg <= '0;
        end else begin
            pkt_valid_reg <= vec_valid_i;
            if (vec_valid_i) begin
                pkt_reg <= pkt_next;
            end
        end
    end
    assign pkt_valid_o = pkt_valid_reg;
    assign pkt_o = pkt_reg;

    // one event per status bit: sent, error, message follows
    wire logic [EV_W-1:0] ev_now;
    assign ev_now[EV_SENT] = vec_valid_i;
    assign ev_now[EV_ERR] = vec_valid_i && err_flag;
    assign ev_now[EV_MSG] = vec_valid_i && has_msg;

    // register write decode
    wire logic sel_clear = reg_addr_i == ADDR_CLEAR;
    wire logic sel_enable_w = reg_addr_i == ADDR_ENABLE;
    wire logic wr_clear = reg_wr_i && sel_clear;
    wire logic wr_enable = reg_wr_i && sel_enable_w;
    wire logic [EV_W-1:0] wr_bits = reg_wdata_i[EV_W-1:0];
    wire logic [EV_W-1:0] clr_mask = wr_clear ? wr_bits : EV_RESET;

    // per-event status, enable and interrupt contribution
    wire logic [EV_W-1:0] status_reg;
    wire logic [EV_W-1:0] enable_reg;
    wire logic [EV_W-1:0] status_next;
    wire logic [EV_W-1:0] enable_next;
    wire logic [EV_W-1:0] irq_bits;
    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++) begin : g_event
            logic status_bit_reg;
            logic enable_bit_reg;
            // set wins over a clear in the same cycle
            assign status_next[gi] = ev_now[gi] ||
                (status_bit_reg && !clr_mask[gi]);
            assign enable_next[gi] = wr_enable ? wr_bits[gi] :
                enable_bit_reg;
            // a fresh enable takes effect in the same cycle
            assign irq_bits[gi] = status_next[gi] && enable_next[gi];
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    status_bit_reg <= EV_RESET[gi];
                    enable_bit_reg <= EV_RESET[gi];
                end else begin
                    status_bit_reg <= status_next[gi];
                    enable_bit_reg <= enable_next[gi];
                end
            end
            assign status_reg[gi] = status_bit_reg;
            assign enable_reg[gi] = enable_bit_reg;
        end
    endgenerate

    // vector counter wraps silently
    logic [CNT_W-1:0] count_reg;
    wire logic [CNT_W-1:0] count_inc = CNT_W'(count_reg + 1'b1);
    wire logic [CNT_W-1:0] count_next = vec_valid_i ?
        count_inc : count_reg;

    // read selection; unmapped addresses read zero
    wire logic sel_status = reg_addr_i == ADDR_STATUS;
    wire logic sel_enable_r = reg_addr_i == ADDR_ENABLE;
    wire logic sel_last = reg_addr_i == ADDR_LAST_PKT;
    wire logic sel_count = reg_addr_i == ADDR_COUNT;
    wire logic [31:0] rd_mux =
        sel_status ? 32'(status_reg) :
        sel_enable_r ? 32'(enable_reg) :
        sel_last ? pkt_reg.bytes :
        sel_count ? 32'(count_reg) : 32'h0;
    // read data stand for one cycle only, zero otherwise
    wire logic [31:0] rdata_next = reg_rd_i ? rd_mux : 32'h0;
    wire logic irq_next = |irq_bits;

    logic irq_reg;
    logic [31:0] rdata_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_reg <= '0;
            irq_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            count_reg <= count_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end
    assign irq_o = irq_reg;
    assign reg_rdata_o = rdata_reg;

endmodule // vector_packet_formatter
`default_nettype wire

// ==== vec_pkt_props.sv ====
// port assertions for the vector packet formatter
`default_nettype none
module vec_pkt_props
    import vec_pkt_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic vec_valid_i,
    input wire vector_in_s vec_i,
    input wire logic pkt_valid_o,
    input wire packet_out_s pkt_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_short;
        vec_valid_i && vec_i.vtype == VT_SHORT_INSTR;
    endsequence
    sequence s_bad;
        vec_valid_i && (vec_i.bit_errs > BIT_ERR_LIMIT || vec_i.check_fail
            || vec_i.invalid);
    endsequence
    a_loc_next: assert property (vec_valid_i |=> pkt_valid_o &&
        pkt_o.bytes[31:24] == {1'h0, $past(vec_i.word_loc)}) else $error("loc");
    a_phase_kept: assert property (vec_valid_i |=>
        pkt_o.bytes[22:21] == $past(vec_i.phase)) else $error("phase");
    a_type_kept: assert property (vec_valid_i |=>
        pkt_o.bytes[18:16] == $past(vec_i.vtype)) else $error("type");
    a_err_causes: assert property (s_bad |=> pkt_o.err
        && pkt_o.bytes[23]) else $error("err not set");
    a_err_bit: assert property (pkt_valid_o |->
        pkt_o.bytes[23] == pkt_o.err) else $error("err bit");
    a_no_msg_err: assert property (pkt_valid_o && pkt_o.err |->
        !pkt_o.has_msg) else $error("msg on err");
    a_long_first: assert property (vec_valid_i && vec_i.long_addr |=>
        pkt_o.first_msg_loc == $past(vec_i.word_loc) + 7'h1) else $error("first");
    a_short_data: assert property (s_short |=> pkt_o.bytes[13:0] ==
        {$past(vec_i.instr_data), $past(vec_i.instr_type)}) else $error("short");
endmodule // vec_pkt_props
bind vector_packet_formatter vec_pkt_props props(.clk_i, .nrst_i,
    .vec_valid_i, .vec_i, .pkt_valid_o, .pkt_o);
`default_nettype wire

// ==== host_pkt_sink.sv ====
// host model: decodes packets by bit position
`default_nettype none
module host_pkt_sink
    import vec_pkt_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pkt_valid_i,
    input wire packet_out_s pkt_i,
    output logic [6:0] loc_o,
    output logic [2:0] vtype_o
);
    // unused bits never reach the decode: their value is not guaranteed
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loc_o <= 7'h00;
            vtype_o <= 3'h0;
        end else if (pkt_valid_i) begin
            loc_o <= pkt_i.bytes[30:24];
            vtype_o <= pkt_i.bytes[18:16];
        end
    end
endmodule // host_pkt_sink
`default_nettype wire

// ==== paging_vector_packet_formatter_tb_top.sv ====
// self-checking bench for the vector packet formatter
`default_nettype none
module paging_vector_packet_formatter_tb_top
    import vec_pkt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = '0, nrst_i = '0, vec_valid_i = '0, reg_wr_i = '0;
    logic reg_rd_i = '0, pkt_valid_o, irq_o;
    logic [3:0] reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, e;
    logic [6:0] hl;
    logic [2:0] ht;
    vector_in_s vec_i = '0, v;
    packet_out_s pkt_o;
    int bad_count = 0, num_checks = 0, nv = 0;
    localparam logic [2:0] NT [3] = '{VT_NUM_STD, VT_NUM_SPECIAL,
        VT_NUM_NUMBERED};
    localparam logic [2:0] MT [3] = '{VT_SECURE, VT_ALPHA, VT_HEX_BIN};
    vector_packet_formatter dut(.clk_i, .nrst_i, .vec_valid_i, .vec_i,
        .pkt_valid_o, .pkt_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .irq_o);
    host_pkt_sink host(.clk_i, .nrst_i, .pkt_valid_i(pkt_valid_o),
        .pkt_i(pkt_o), .loc_o(hl), .vtype_o(ht));
    initial forever #4 clk_i = ~clk_i;
    task chk(input string s, input logic [31:0] seen, x);
        num_checks++;
        if (seen !== x) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", s, x, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'h1, a, d};
        @(posedge clk_i) reg_wr_i <= 1'h0;
    endtask
    task rd(input string s, input logic [3:0] a, input logic [31:0] x);
        @(posedge clk_i) {reg_rd_i, reg_addr_i} <= {1'h1, a};
        @(posedge clk_i) reg_rd_i <= 1'h0;
        #1 chk(s, reg_rdata_o, x);
    endtask
    function automatic logic [31:0] pk(input logic [2:0] t,
        input logic [6:0] l, input logic [1:0] p, input logic [14:0] m);
        return {1'h0, l, m[14], p, 2'h0, t, 2'h0, m[13:0]};
    endfunction
    // m carries the error flag on top of the 14 low bits
    task snd(input logic [31:0] x, input logic hm, input logic [6:0] fl);
        @(posedge clk_i) {vec_valid_i, vec_i} <= {1'h1, v};
        @(posedge clk_i) vec_valid_i <= 1'h0;
        #1 nv++;
        e = x;
        chk("valid", pkt_valid_o, 1'h1);
        chk("bytes", pkt_o.bytes, x);
        chk("err", pkt_o.err, x[23]);
        chk("msg", pkt_o.has_msg, hm);
        if (hm) chk("first", pkt_o.first_msg_loc, fl);
        @(posedge clk_i) #1 chk("host loc", hl, x[30:24]);
        chk("host type", ht, x[18:16]);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'h1;
        rd("enable", ADDR_ENABLE, 32'h0);
        for (int i = 0; i < 3; i++) begin
            v = '0;
            {v.vtype, v.word_loc, v.phase, v.long_addr} = {NT[i], 7'h0a,
                2'(i + 1), 1'h1};
            {v.check_bits, v.word_count, v.start_word} = {4'ha, 7'h03, 7'h0c};
            v.bit_errs = BIT_ERR_LIMIT;
            snd(pk(NT[i], 7'h0a, v.phase, {5'h0a, 3'h2, 7'h0c}), 1'h1,
                7'h0b);
            v = '0;
            {v.vtype, v.word_loc, v.long_addr} = {MT[i], 7'h56, i[0]};
            {v.word_count, v.start_word} = {COUNT_MAX, START_MAX};
            snd(pk(MT[i], 7'h56, 2'h0, {1'h0, COUNT_MAX, START_MAX}), 1'h1,
                7'h57);
        end
        v = '0;
        {v.vtype, v.word_loc} = {VT_SHORT_INSTR, WORD_LOC_MIN};
        {v.instr_data, v.instr_type} = {11'h5a3, 3'h6};
        snd(pk(VT_SHORT_INSTR, WORD_LOC_MIN, 2'h0, {1'h0, 11'h5a3, 3'h6}),
            1'h0,
            7'h00);
        chk("irq masked", irq_o, 1'h0);
        rd("status", ADDR_STATUS, 32'h5);
        wr(ADDR_CLEAR, 32'h7);
        rd("cleared", ADDR_STATUS, 32'h0);
        wr(ADDR_ENABLE, 32'h2);
        for (int i = 0; i < 4; i++) begin
            v = '0;
            {v.vtype, v.word_loc, v.word_count} = {VT_NUM_STD, 7'h20, 7'h01};
            if (i == 3) v.word_count = 7'h09;
            {v.bit_errs, v.check_fail, v.invalid} = {{2{i == 0}}, i == 1,
                i == 2};
            v.start_word = START_MIN;
            snd(pk(VT_NUM_STD, 7'h20, 2'h0, {5'h10, NUM_LEN_ONE, START_MIN}),
                1'h0, 7'h00);
        end
        chk("irq", irq_o, 1'h1);
        rd("last", ADDR_LAST_PKT, e);
        rd("count", ADDR_COUNT, nv);
        rd("unmapped", 4'hf, 32'h0);
        wr(ADDR_CLEAR, 32'h7);
        @(posedge clk_i) #1 chk("irq off", irq_o, 1'h0);
        wrap_up;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        wrap_up;
    end
endmodule // paging_vector_packet_formatter_tb_top
`default_nettype wire
